// ### src/fpu_nan_defs.svh
// Bit positions, field widths and reset values of the NaN propagation datapath.
// Assumes it is included by its bare name wherever a module needs these figures.
`ifndef FPU_NAN_DEFS_SVH
`define FPU_NAN_DEFS_SVH

// ****************************************************************
// Fixed compatibility flag positions
// ****************************************************************
`define FP_STD_REV_BIT    23
`define FP_FUSED_MA_BIT   20
`define FP_SIGN_OPS_BIT   19
`define FP_NAN_ENC_BIT    18

// ****************************************************************
// Binary format fields
// ****************************************************************
`define FP_DBL_SIGN_BIT   63
`define FP_DBL_MANT_W     52
`define FP_DBL_EXP_ONES   11'h7FF
`define FP_SGL_SIGN_BIT   31
`define FP_SGL_MANT_W     23
`define FP_SGL_EXP_ONES   8'hFF
`define FP_WIDEN_SHIFT    29

// ****************************************************************
// Reset values
// ****************************************************************
`define FP_RESULT_RST     64'h0000000000000000

`endif

// ### src/fpu_nan_pkg.sv
// Types shared by the NaN propagation datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package fpu_nan_pkg;

  // ****************************************************************
  // Operation classes seen by the NaN path
  // ****************************************************************
  typedef enum logic [3:0] {
    op_arith2             = 4'h0,
    op_abs                = 4'h1,
    op_neg                = 4'h2,
    op_muladd             = 4'h3,
    op_negated_mul_add    = 4'h4,
    op_negated_mul_sub    = 4'h5,
    op_narrow_precision   = 4'h6,
    op_widen_precision    = 4'h7
  } nan_op_t;

endpackage

// ### src/nan_class_if.sv
// Interface between the NaN datapath and its operand classifier.
// Assumes both ends sit in the core clock domain; all signals are combinational.
`timescale 1ns/1ps
`default_nettype none

interface nan_class_if;
  logic [63:0] opnd [3];
  logic        is_double;
  logic [2:0]  is_nan;
  logic [2:0]  is_snan;
  logic [2:0]  sign;
  logic [51:0] mant_al [3];

  modport classifier (
    input  opnd,
    input  is_double,
    output is_nan,
    output is_snan,
    output sign,
    output mant_al
  );

  modport consumer (
    output opnd,
    output is_double,
    input  is_nan,
    input  is_snan,
    input  sign,
    input  mant_al
  );
endinterface

`default_nettype wire

// ### src/nan_operand_classify.sv
// Classifies three operands as NaN or signaling NaN and aligns their mantissas.
// Assumes single operands sit in the low 32 bits; mantissas come out left-aligned to 52 bits.
`timescale 1ns/1ps
`default_nettype none
`include "fpu_nan_defs.svh"

module nan_operand_classify (
  nan_class_if.classifier cls
);

  // ****************************************************************
  // Per-operand field extraction
  // ****************************************************************
  for (genvar k = 0; k < 3; k++) begin : g_opnd
    logic        exp_ones;
    logic [51:0] mant;

    // Single fields widen to the double layout so later stages see one format
    assign exp_ones = cls.is_double ?
                      (cls.opnd[k][62:`FP_DBL_MANT_W] == `FP_DBL_EXP_ONES) :
                      (cls.opnd[k][30:`FP_SGL_MANT_W] == `FP_SGL_EXP_ONES);
    assign mant     = cls.is_double ? cls.opnd[k][`FP_DBL_MANT_W-1:0] :
                      {cls.opnd[k][`FP_SGL_MANT_W-1:0], 29'h00000000};

    assign cls.mant_al[k] = mant;
    assign cls.is_nan[k]  = exp_ones && (mant != 52'h0000000000000);
    assign cls.is_snan[k] = exp_ones && (mant != 52'h0000000000000) && !mant[51];
    assign cls.sign[k]    = cls.is_double ? cls.opnd[k][`FP_DBL_SIGN_BIT] :
                            cls.opnd[k][`FP_SGL_SIGN_BIT];
  end

endmodule

`default_nettype wire

// ### src/fpu_nan_propagation_2008.sv
// NaN selection and propagation datapath with the fixed compatibility flags.
// Assumes the dispatching pipeline drives all inputs from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "fpu_nan_defs.svh"

module fpu_nan_propagation_2008
  import fpu_nan_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Request
  input  wire logic        i_valid,
  input  wire nan_op_t     i_op,
  input  wire logic        i_is_double,
  input  wire logic        i_need_nan,
  input  wire logic        i_invalid_trap_en,
  input  wire logic [63:0] i_primary_source_operand,
  input  wire logic [63:0] i_second_source_operand,
  input  wire logic [63:0] i_addend_operand,
  // Result
  output logic             o_valid,
  output logic [63:0]      o_result,
  output logic             o_result_is_nan,
  output logic             o_signaling_seen,
  // Fixed compatibility flags
  output logic             o_std_revision_support_flag,
  output logic             o_fused_muladd_flag,
  output logic             o_sign_ops_nonarith_flag,
  output logic             o_nan_encoding_flag,
  output logic [31:0]      o_fpu_implementation_reg,
  output logic [31:0]      o_fpu_control_status_reg
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Lowest set index gives primary, second, addend precedence
  function automatic logic [1:0] first_of(input logic [2:0] m);
    logic [1:0] r;
    r = 2'h0;
    if (m[0]) begin
      r = 2'h0;
    end else if (m[1]) begin
      r = 2'h1;
    end else if (m[2]) begin
      r = 2'h2;
    end
    return r;
  endfunction

  function automatic logic [51:0] quiet_mant(input logic [51:0] m, input logic dbl);
    logic [51:0] q;
    q = m;
    if (!q[51]) begin
      q[51] = ~q[51];
    end
    if (dbl ? (q == 52'h0000000000000) : (q[51:`FP_WIDEN_SHIFT] == 23'h000000)) begin
      q[50] = 1'b1;
    end
    return q;
  endfunction

  // Exponent forced to all ones in either format
  function automatic logic [63:0] pack_nan(input logic s, input logic [51:0] m,
                                           input logic dbl);
    logic [63:0] r;
    if (dbl) begin
      r = {s, `FP_DBL_EXP_ONES, m};
    end else begin
      r = {32'h00000000, s, `FP_SGL_EXP_ONES, m[51:`FP_WIDEN_SHIFT]};
    end
    return r;
  endfunction

  // ****************************************************************
  // Fixed compatibility flags
  // ****************************************************************
  assign o_std_revision_support_flag = 1'b1;
  assign o_fused_muladd_flag         = 1'b0;
  assign o_sign_ops_nonarith_flag    = 1'b1;
  assign o_nan_encoding_flag         = 1'b1;

  always_comb begin
    o_fpu_implementation_reg                   = 32'h00000000;
    o_fpu_implementation_reg[`FP_STD_REV_BIT]  = o_std_revision_support_flag;
    o_fpu_control_status_reg                   = 32'h00000000;
    o_fpu_control_status_reg[`FP_FUSED_MA_BIT] = o_fused_muladd_flag;
    o_fpu_control_status_reg[`FP_SIGN_OPS_BIT] = o_sign_ops_nonarith_flag;
    o_fpu_control_status_reg[`FP_NAN_ENC_BIT]  = o_nan_encoding_flag;
  end

  // ****************************************************************
  // Operand classification
  // ****************************************************************
  nan_class_if cls_bus ();

  assign cls_bus.opnd[0]   = i_primary_source_operand;
  assign cls_bus.opnd[1]   = i_second_source_operand;
  assign cls_bus.opnd[2]   = i_addend_operand;
  // Narrowing reads a double source, widening a single one
  assign cls_bus.is_double = (i_op == op_narrow_precision) ? 1'b1 :
                             (i_op == op_widen_precision)  ? 1'b0 : i_is_double;

  nan_operand_classify u_classify (
    .cls (cls_bus)
  );

  // ****************************************************************
  // NaN selection
  // ****************************************************************
  logic [2:0]  nan_v;
  logic [2:0]  snan_v;
  logic [1:0]  sel;
  logic [1:0]  prod_sel;
  logic [2:0]  used;
  logic        hit;
  logic        dest_dbl;
  logic        sign_op;
  logic        sel_sign;
  logic [51:0] sel_mant;
  logic [63:0] next_result;
  logic        next_is_nan;
  logic        next_sig;

  assign nan_v   = cls_bus.is_nan;
  assign snan_v  = cls_bus.is_snan;
  assign sign_op = (i_op == op_abs) || (i_op == op_neg);

  always_comb begin
    sel      = 2'h0;
    used     = 3'b001;
    prod_sel = snan_v[1:0] != 2'b00 ? first_of({1'b0, snan_v[1:0]}) :
                                      first_of({1'b0, nan_v[1:0]});
    dest_dbl = i_is_double;
    case (i_op)
      op_arith2: begin
        used = 3'b011;
        sel  = ((snan_v & used) != 3'b000) ? first_of(snan_v & used) :
                                             first_of(nan_v & used);
      end
      op_muladd, op_negated_mul_add, op_negated_mul_sub: begin
        used = 3'b111;
        if (snan_v[2] && !((snan_v[1:0] != 2'b00) && i_invalid_trap_en)) begin
          sel = 2'h2;
        end else if (nan_v[1:0] != 2'b00) begin
          sel = prod_sel;
        end else begin
          sel = 2'h2;
        end
      end
      op_narrow_precision: begin
        dest_dbl = 1'b0;
      end
      op_widen_precision: begin
        dest_dbl = 1'b1;
      end
      default: begin
        sel = 2'h0;
      end
    endcase
  end

  assign hit      = (nan_v & used) != 3'b000;
  assign sel_sign = cls_bus.sign[sel];
  // Quiet mantissa is untouched; left alignment gives zero low bits on widening
  assign sel_mant = quiet_mant(cls_bus.mant_al[sel], cls_bus.is_double);

  always_comb begin
    next_result = `FP_RESULT_RST;
    next_is_nan = 1'b0;
    next_sig    = 1'b0;
    if (sign_op) begin
      // Sign ops are bit operations: no quieting and no exception
      next_result = i_primary_source_operand;
      if (i_is_double) begin
        next_result[`FP_DBL_SIGN_BIT] = (i_op == op_neg) ?
                                        ~i_primary_source_operand[`FP_DBL_SIGN_BIT] : 1'b0;
      end else begin
        next_result[`FP_SGL_SIGN_BIT] = (i_op == op_neg) ?
                                        ~i_primary_source_operand[`FP_SGL_SIGN_BIT] : 1'b0;
      end
      next_is_nan = nan_v[0];
    end else if (hit) begin
      next_result = pack_nan(sel_sign, sel_mant, dest_dbl);
      next_is_nan = 1'b1;
      next_sig    = (snan_v & used) != 3'b000;
    end else if (i_need_nan) begin
      next_result = pack_nan(1'b0, 52'hFFFFFFFFFFFFF, dest_dbl);
      next_is_nan = 1'b1;
    end
  end

  // ****************************************************************
  // Result register
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_valid          <= 1'b0;
      o_result         <= `FP_RESULT_RST;
      o_result_is_nan  <= 1'b0;
      o_signaling_seen <= 1'b0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_result         <= next_result;
        o_result_is_nan  <= next_is_nan;
        o_signaling_seen <= next_sig;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_dbl_take(nan_op_t op, logic cond);
    i_valid && i_is_double && (i_op == op) && cond;
  endsequence

  sequence s_all_quiet_fma;
    s_dbl_take(op_muladd, (nan_v == 3'b111) && (snan_v == 3'b000));
  endsequence

  sequence s_all_snan_fma;
    s_dbl_take(op_muladd, (snan_v == 3'b111) && !i_invalid_trap_en);
  endsequence

  chk_flag_words: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_fpu_implementation_reg[`FP_STD_REV_BIT] && !o_fpu_control_status_reg[`FP_FUSED_MA_BIT]
    && o_fpu_control_status_reg[`FP_SIGN_OPS_BIT] && o_fpu_control_status_reg[`FP_NAN_ENC_BIT])
    else $error("compatibility flags wrong");

  chk_fused_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_fused_muladd_flag && o_nan_encoding_flag)
    else $error("fused or encoding flag wrong");

  chk_abs_bitop: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_dbl_take(op_abs, 1'b1) |=> !o_result[`FP_DBL_SIGN_BIT] && !o_signaling_seen
    && (o_result[62:0] == $past(i_primary_source_operand[62:0])))
    else $error("abs is not a bit operation");

  chk_quiet_prio: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_dbl_take(op_arith2, (snan_v == 3'b000) && nan_v[1] && !nan_v[0])
    |=> o_valid && (o_result == $past(i_second_source_operand)))
    else $error("quiet NaN precedence wrong");

  chk_snan_quieted: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_dbl_take(op_arith2, snan_v[1] && !snan_v[0])
    |=> o_result_is_nan && o_signaling_seen && o_result[51]
    && (o_result[50:0] == $past(i_second_source_operand[50:0])))
    else $error("signaling NaN not quieted");

  chk_negated_sign: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_dbl_take(op_negated_mul_sub, nan_v[0] && (snan_v == 3'b000))
    |=> o_result[`FP_DBL_SIGN_BIT] == $past(i_primary_source_operand[`FP_DBL_SIGN_BIT]))
    else $error("negated op flipped NaN sign");

  chk_product_wins: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_all_quiet_fma |=> o_result == $past(i_primary_source_operand))
    else $error("product NaN lost to addend");

  chk_addend_wins: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_all_snan_fma |=> o_result[50:0] == $past(i_addend_operand[50:0]))
    else $error("signaling addend lost");

  chk_narrow_keep: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_valid && (i_op == op_narrow_precision) && nan_v[0] && !snan_v[0]
    |=> (o_result[63:32] == 32'h00000000)
    && (o_result[22:0] == $past(i_primary_source_operand[51:29])))
    else $error("narrowing lost upper mantissa");

  chk_widen_pad: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_valid && (i_op == op_widen_precision) && nan_v[0]
    |=> (o_result[28:0] == 29'h00000000) && (o_result[62:52] == `FP_DBL_EXP_ONES))
    else $error("widening padding wrong");

  chk_default_nan: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_dbl_take(op_arith2, i_need_nan && (nan_v == 3'b000))
    |=> o_result == {1'b0, `FP_DBL_EXP_ONES, 52'hFFFFFFFFFFFFF})
    else $error("default NaN wrong");

endmodule

`default_nettype wire

// ### verification/fp_dispatch_model.sv
// Partner model: the integer pipeline that dispatches requests into the NaN datapath.
// Assumes one core clock; requests change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none

module fp_dispatch_model
  import fpu_nan_pkg::*;
(
  // Clock
  input  wire logic        i_clk,
  // Request
  output var logic         o_valid,
  output var nan_op_t      o_op,
  output var logic         o_is_double,
  output var logic         o_need_nan,
  output var logic         o_trap_en,
  output var logic [63:0]  o_primary_source_operand,
  output var logic [63:0]  o_second_source_operand,
  output var logic [63:0]  o_addend_operand
);
  initial begin
    o_valid = 1'b0;
    o_op = op_arith2;
    {o_is_double, o_need_nan, o_trap_en} = 3'h0;
    {o_primary_source_operand, o_second_source_operand, o_addend_operand} = '0;
  end

  // One request, taken at the next rising edge
  task automatic issue(input nan_op_t op, input logic dbl, need, trap,
                       input logic [63:0] a, b, c);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_op = op;
    o_is_double = dbl;
    o_need_nan = need;
    o_trap_en = trap;
    o_primary_source_operand = a;
    o_second_source_operand = b;
    o_addend_operand = c;
  endtask

  // Idle cycle: operands no longer meaningful, so they show inverted junk
  task automatic idle();
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    o_primary_source_operand = ~o_primary_source_operand;
    o_second_source_operand = ~o_second_source_operand;
    o_addend_operand = ~o_addend_operand;
  endtask
endmodule

`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the NaN propagation datapath.
// Assumes the dispatch model drives all requests; results are sampled on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                  i_clk, i_resetn, v, dbl, need, trap, ov, isn, sig;
  logic                  f0, f1, f2, f3;
  fpu_nan_pkg::nan_op_t  op;
  logic [63:0]           pa, pb, pc, res;
  logic [31:0]           fpu_implementation_reg, fcs;
  logic [65:0]           q[$];
  logic [65:0]           note;
  int                    bad_count = 0;
  int                    comparisons = 0;
  int                    seed = 32'h743B86EA;

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  fp_dispatch_model fp_dispatch_model_i (.i_clk(i_clk), .o_valid(v), .o_op(op),
    .o_is_double(dbl), .o_need_nan(need), .o_trap_en(trap), .o_primary_source_operand(pa),
    .o_second_source_operand(pb), .o_addend_operand(pc));

  fpu_nan_propagation_2008 fpu_nan_propagation_2008_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_valid(v), .i_op(op), .i_is_double(dbl), .i_need_nan(need), .i_invalid_trap_en(trap),
    .i_primary_source_operand(pa), .i_second_source_operand(pb), .i_addend_operand(pc),
    .o_valid(ov), .o_result(res), .o_result_is_nan(isn), .o_signaling_seen(sig),
    .o_std_revision_support_flag(f0), .o_fused_muladd_flag(f1),
    .o_sign_ops_nonarith_flag(f2), .o_nan_encoding_flag(f3),
    .o_fpu_implementation_reg(fpu_implementation_reg), .o_fpu_control_status_reg(fcs));

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Operand of kind 0 number, 1 quiet NaN, 2 signaling NaN
  function automatic logic [63:0] mk(input int kind, input logic d, input logic [63:0] r);
    if (d) begin
      return (kind == 0) ? {r[63], 11'h3FF, r[51:0]} :
             (kind == 1) ? {r[63], 11'h7FF, 1'b1, r[50:0]} : {r[63], 11'h7FF, 1'b0, r[50:1], 1'b1};
    end
    return (kind == 0) ? {32'h0, r[31], 8'h7F, r[22:0]} :
           (kind == 1) ? {32'h0, r[31], 8'hFF, 1'b1, r[21:0]} : {32'h0, r[31], 8'hFF, 2'h0, r[20:0]};
  endfunction

  // Expected {result, is_nan, signaling_seen}
  function automatic logic [65:0] model(input int o, input logic dd, nd, tr,
                                        input logic [63:0] a, b, c);
    logic [63:0] x[3];
    logic [2:0]  n, s;
    logic [51:0] m;
    logic [63:0] r;
    logic        d, od, sg, sv;
    int          k;
    x[0] = a;
    x[1] = b;
    x[2] = c;
    d = (o == 6) ? 1'b1 : (o == 7) ? 1'b0 : dd;
    od = (o == 6) ? 1'b0 : (o == 7) ? 1'b1 : dd;
    for (int i = 0; i < 3; i++) begin
      n[i] = d ? (x[i][62:52] == 11'h7FF && x[i][51:0] != 52'h0) :
                 (x[i][30:23] == 8'hFF && x[i][22:0] != 23'h0);
      s[i] = n[i] & ~(d ? x[i][51] : x[i][22]);
    end
    if (o == 1 || o == 2) begin
      r = d ? {(o == 2) & ~a[63], a[62:0]} : {32'h0, (o == 2) & ~a[31], a[30:0]};
      return {r, n[0], 1'b0};
    end
    k = s[0] ? 0 : s[1] ? 1 : n[0] ? 0 : n[1] ? 1 : -1;
    sv = s[0] | s[1];
    if (o >= 3 && o <= 5) begin
      sv = |s;
      if (s[2] && !((s[0] | s[1]) && tr)) k = 2;
      else if (k < 0 && n[2]) k = 2;
    end
    if (o >= 6) begin
      k = n[0] ? 0 : -1;
      sv = s[0];
    end
    if (k < 0) begin
      r = !nd ? 64'h0 : od ? 64'h7FFFFFFFFFFFFFFF : 64'h000000007FFFFFFF;
      return {r, nd, sv};
    end
    m = d ? x[k][51:0] : {x[k][22:0], 29'h0};
    sg = d ? x[k][63] : x[k][31];
    if (s[k]) begin
      m[51] = ~m[51];
      if (m == 52'h0) m[50] = 1'b1;
    end
    r = od ? {sg, 11'h7FF, m} : {32'h0, sg, 8'hFF, m[51:29]};
    return {r, 1'b1, sv};
  endfunction

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(negedge i_clk) begin
    if (i_resetn === 1'b1 && ov !== 1'b0) begin
      if (q.size() == 0) begin
        check({63'h0, ov}, 64'h0);
      end else begin
        note = q.pop_front();
        check(res, note[65:2]);
        check({63'h0, isn}, {63'h0, note[1]});
        check({63'h0, sig}, {63'h0, note[0]});
      end
    end
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic        sd;
    logic [63:0] a, b, c;
    i_resetn = 1'b0;
    repeat (20) @(posedge i_clk);
    check({63'h0, ov}, 64'h0);
    check(res, 64'h0);
    #1 i_resetn = 1'b1;
    for (int o = 0; o < 8; o++) begin
      for (int k = 0; k < 27; k++) begin
        r = $random(seed);
        sd = (o == 6) ? 1'b1 : (o == 7) ? 1'b0 : r[0];
        a = mk(k % 3, sd, {$random(seed), $random(seed)});
        b = mk((k / 3) % 3, sd, {$random(seed), $random(seed)});
        c = mk(k / 9, sd, {$random(seed), $random(seed)});
        q.push_back(model(o, r[0], r[1], r[2], a, b, c));
        fp_dispatch_model_i.issue(fpu_nan_pkg::nan_op_t'(o[3:0]), r[0], r[1], r[2], a, b, c);
        if (r[3]) fp_dispatch_model_i.idle();
      end
    end
    fp_dispatch_model_i.idle();
    for (int w = 0; w < 10 && q.size() > 0; w++) @(posedge i_clk);
    if (q.size() > 0) bad_count++;
    check({63'h0, f0}, 64'h1);
    check({63'h0, f1}, 64'h0);
    check({63'h0, f2}, 64'h1);
    check({63'h0, f3}, 64'h1);
    check({32'h0, fpu_implementation_reg}, 64'h0000000000800000);
    check({32'h0, fcs}, 64'h00000000000C0000);
    conclude();
  end

  initial begin
    #4000000;
    bad_count++;
    conclude();
  end
endmodule

`default_nettype wire
